// *** verilog/setpoint_drive.sv ***
// drive end: profile records, configuration objects, pointers and reference fifo
// Operation
// - queue style 0 is fifo, 1 is ring
// - master keeps style, entry, select while enabled
// - entry point field 1 to 254, default 1
// - buffer control write 0 disables, 1 enables
// - abs/rel 0 absolute, 1 relative increment
// - abs/rel and sign change only when pointers equal
// - sign invert 1 negates set point
// - sign invert acts only on relative data
// - drained and idle: hold or reinit read pointer
// - drain behaviour ignored in ring style
// - profile select chooses record and configuration
// - profile select writable only while interpolation off
// - 254 signed 32-bit entries per record, zero default
// - master configures profile before loading set points
// - master sets interpolation enable after loading
// - read and write pointers readable, 1 to 254
`timescale 1ns/1ps
module ref_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] head_r;
  logic [AW-1:0] tail_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[head_r];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[tail_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      head_r <= '0;
      tail_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        tail_r <= (tail_r == AW'(DEPTH - 1)) ? '0 : tail_r + 1'b1;
      end
      if (pop) begin
        head_r <= (head_r == AW'(DEPTH - 1)) ? '0 : head_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ref_fifo

module setpoint_drive (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // object link
  setpoint_if.drive link,
  // control cycle and position reference out
  input wire logic cycle_tick,
  output logic ref_valid,
  input wire logic ref_ready,
  output logic [31:0] ref_data,
  // pointer monitor
  output logic [7:0] rd_ptr,
  output logic [7:0] wr_ptr
);
  logic signed [31:0] rec_r [2][254];
  logic [31:0] act_depth_r [2];
  logic queue_style_r [2];
  logic [7:0] entry_point_r [2];
  logic buf_enable_r [2];
  logic abs_rel_r [2];
  logic sign_inv_r [2];
  logic drain_r [2];
  logic sel_r;
  logic [7:0] rd_ptr_r;
  logic [7:0] wr_ptr_r;
  logic signed [31:0] pos_r;
  logic ack_r;
  logic err_r;
  logic [31:0] rdata_r;
  logic wr_ok;
  logic wr_bad;
  logic is_cfg;
  logic cfg_p;
  logic is_rec;
  logic rec_p;
  logic sub_in_rec;
  logic ptrs_equal;
  logic consume;
  logic signed [31:0] cur;
  logic signed [31:0] delta;
  logic signed [31:0] next_pos;
  logic fifo_ready;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p == setpoint_pkg::PTR_LAST) ? setpoint_pkg::PTR_FIRST : p + 8'h01;
  endfunction : next_ptr

  function automatic logic in_range(input logic [31:0] v);
    in_range = (v >= 32'(setpoint_pkg::PTR_FIRST)) && (v <= 32'(setpoint_pkg::PTR_LAST));
  endfunction : in_range

  assign is_cfg = (link.index == setpoint_pkg::IDX_CFG_FIRST) ||
                  (link.index == setpoint_pkg::IDX_CFG_SECOND);
  assign cfg_p = (link.index == setpoint_pkg::IDX_CFG_SECOND);
  assign is_rec = (link.index == setpoint_pkg::IDX_REC_FIRST) ||
                  (link.index == setpoint_pkg::IDX_REC_SECOND);
  assign rec_p = (link.index == setpoint_pkg::IDX_REC_SECOND);
  assign sub_in_rec = in_range(32'(link.sub));
  assign ptrs_equal = (rd_ptr_r == wr_ptr_r);

  // decide whether a write is legal in the present state
  always_comb begin
    wr_ok = 1'b0;
    if (is_rec) begin
      wr_ok = sub_in_rec;
    end else if (link.index == setpoint_pkg::IDX_PROFILE_SEL) begin
      wr_ok = !link.interp_enable && (link.wdata <= 32'h1);
    end else if (is_cfg) begin
      unique case (link.sub)
        setpoint_pkg::SUB_ACT_DEPTH: wr_ok = 1'b1;
        setpoint_pkg::SUB_QUEUE_STYLE, setpoint_pkg::SUB_BUF_ENABLE,
        setpoint_pkg::SUB_DRAIN: wr_ok = (link.wdata <= 32'h1);
        setpoint_pkg::SUB_RECORD_SIZE: wr_ok = (link.wdata == 32'(setpoint_pkg::RECORD_SIZE));
        setpoint_pkg::SUB_ENTRY_POINT: wr_ok = in_range(link.wdata);
        setpoint_pkg::SUB_ABS_REL, setpoint_pkg::SUB_SIGN_INV:
          wr_ok = ptrs_equal && (link.wdata <= 32'h1);
        default: wr_ok = 1'b0;
      endcase
    end
  end
  assign wr_bad = link.req && link.we && !wr_ok;

  // active profile record and configuration
  assign cur = rec_r[sel_r][rd_ptr_r - 8'h01];
  assign delta = sign_inv_r[sel_r] ? -cur : cur;
  always_comb begin
    if (abs_rel_r[sel_r] == setpoint_pkg::DATA_RELATIVE) begin
      next_pos = pos_r + delta;
    end else begin
      next_pos = cur;
    end
  end
  assign consume = ce && cycle_tick && link.interp_enable && buf_enable_r[sel_r] && fifo_ready &&
                   ((queue_style_r[sel_r] == setpoint_pkg::QUEUE_RING) || !ptrs_equal);

  // set-point storage
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < 254; i++) begin
          rec_r[p][i] <= '0;
        end
      end
    end else if (ce && link.req && link.we && is_rec && wr_ok) begin
      rec_r[rec_p][link.sub - 8'h01] <= link.wdata;
    end
  end

  // per-profile configuration
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int p = 0; p < 2; p++) begin
        act_depth_r[p] <= setpoint_pkg::ACT_DEPTH_RST;
        queue_style_r[p] <= setpoint_pkg::QUEUE_FIFO;
        entry_point_r[p] <= setpoint_pkg::PTR_FIRST;
        buf_enable_r[p] <= 1'b0;
        abs_rel_r[p] <= setpoint_pkg::DATA_ABSOLUTE;
        sign_inv_r[p] <= 1'b0;
        drain_r[p] <= setpoint_pkg::DRAIN_HOLD;
      end
    end else if (ce && link.req && link.we && is_cfg && wr_ok) begin
      unique case (link.sub)
        setpoint_pkg::SUB_ACT_DEPTH: act_depth_r[cfg_p] <= link.wdata;
        setpoint_pkg::SUB_QUEUE_STYLE: queue_style_r[cfg_p] <= link.wdata[0];
        setpoint_pkg::SUB_ENTRY_POINT: entry_point_r[cfg_p] <= link.wdata[7:0];
        setpoint_pkg::SUB_BUF_ENABLE: buf_enable_r[cfg_p] <= link.wdata[0];
        setpoint_pkg::SUB_ABS_REL: abs_rel_r[cfg_p] <= link.wdata[0];
        setpoint_pkg::SUB_SIGN_INV: sign_inv_r[cfg_p] <= link.wdata[0];
        setpoint_pkg::SUB_DRAIN: drain_r[cfg_p] <= link.wdata[0];
        default: ;
      endcase
    end
  end

  // profile select
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sel_r <= 1'b0;
    end else if (ce && link.req && link.we && wr_ok &&
                 link.index == setpoint_pkg::IDX_PROFILE_SEL) begin
      sel_r <= link.wdata[0];
    end
  end

  // read and write pointers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_ptr_r <= setpoint_pkg::PTR_FIRST;
      wr_ptr_r <= setpoint_pkg::PTR_FIRST;
    end else if (ce) begin
      if (link.req && link.we && is_cfg && cfg_p == sel_r && wr_ok &&
          link.sub == setpoint_pkg::SUB_BUF_ENABLE && !link.wdata[0]) begin
        rd_ptr_r <= setpoint_pkg::PTR_FIRST;
        wr_ptr_r <= setpoint_pkg::PTR_FIRST;
      end else begin
        if (link.req && link.we && is_cfg && cfg_p == sel_r && wr_ok &&
            link.sub == setpoint_pkg::SUB_ENTRY_POINT) begin
          wr_ptr_r <= link.wdata[7:0];
        end else if (link.req && link.we && is_rec && rec_p == sel_r && wr_ok) begin
          wr_ptr_r <= next_ptr(wr_ptr_r);
        end
        if (consume) begin
          rd_ptr_r <= next_ptr(rd_ptr_r);
        end else if (ptrs_equal && !link.interp_enable &&
                     queue_style_r[sel_r] == setpoint_pkg::QUEUE_FIFO &&
                     drain_r[sel_r] == setpoint_pkg::DRAIN_REINIT) begin
          rd_ptr_r <= setpoint_pkg::PTR_FIRST;
        end
      end
    end
  end

  // running position for relative data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pos_r <= '0;
    end else if (ce && !buf_enable_r[sel_r]) begin
      pos_r <= '0;
    end else if (consume) begin
      pos_r <= next_pos;
    end
  end

  // object read answers and write status, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= '0;
    end else if (ce) begin
      ack_r <= link.req;
      err_r <= wr_bad;
      rdata_r <= '0;
      if (link.req && !link.we) begin
        if (is_rec) begin
          rdata_r <= (link.sub == setpoint_pkg::SUB_COUNT) ? 32'(setpoint_pkg::REC_ENTRY_COUNT) :
                     sub_in_rec ? rec_r[rec_p][link.sub - 8'h01] : '0;
          err_r <= (link.sub != setpoint_pkg::SUB_COUNT) && !sub_in_rec;
        end else if (link.index == setpoint_pkg::IDX_PROFILE_SEL) begin
          rdata_r <= 32'(sel_r);
        end else if (link.index == setpoint_pkg::IDX_PTR_MON) begin
          unique case (link.sub)
            setpoint_pkg::SUB_COUNT: rdata_r <= 32'(setpoint_pkg::PTR_ENTRY_COUNT);
            setpoint_pkg::SUB_RD_PTR: rdata_r <= 32'(rd_ptr_r);
            setpoint_pkg::SUB_WR_PTR: rdata_r <= 32'(wr_ptr_r);
            default: err_r <= 1'b1;
          endcase
        end else if (is_cfg) begin
          unique case (link.sub)
            setpoint_pkg::SUB_COUNT: rdata_r <= 32'(setpoint_pkg::CFG_ENTRY_COUNT);
            setpoint_pkg::SUB_MAX_DEPTH: rdata_r <= setpoint_pkg::MAX_DEPTH;
            setpoint_pkg::SUB_ACT_DEPTH: rdata_r <= act_depth_r[cfg_p];
            setpoint_pkg::SUB_QUEUE_STYLE: rdata_r <= 32'(queue_style_r[cfg_p]);
            setpoint_pkg::SUB_ENTRY_POINT: rdata_r <= 32'(entry_point_r[cfg_p]);
            setpoint_pkg::SUB_ABS_REL: rdata_r <= 32'(abs_rel_r[cfg_p]);
            setpoint_pkg::SUB_SIGN_INV: rdata_r <= 32'(sign_inv_r[cfg_p]);
            setpoint_pkg::SUB_DRAIN: rdata_r <= 32'(drain_r[cfg_p]);
            default: err_r <= 1'b1;
          endcase
        end else begin
          err_r <= 1'b1;
        end
      end
    end
  end

  assign link.ack = ack_r;
  assign link.err = err_r;
  assign link.rdata = rdata_r;
  assign rd_ptr = rd_ptr_r;
  assign wr_ptr = wr_ptr_r;

  ref_fifo #(
    .WIDTH(setpoint_pkg::REF_FIFO_WIDTH),
    .DEPTH(setpoint_pkg::REF_FIFO_DEPTH)
  ) u_ref_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .in_valid(consume),
    .in_ready(fifo_ready),
    .in_data(next_pos),
    .out_valid(ref_valid),
    .out_ready(ref_ready),
    .out_data(ref_data)
  );
endmodule : setpoint_drive

// *** verilog/setpoint_pkg.sv ***
// constants shared by both ends of the set-point buffer link
package setpoint_pkg;
  localparam logic [15:0] IDX_CFG_FIRST = 16'h2730;
  localparam logic [15:0] IDX_CFG_SECOND = 16'h2731;
  localparam logic [15:0] IDX_PROFILE_SEL = 16'h2732;
  localparam logic [15:0] IDX_REC_FIRST = 16'h27C0;
  localparam logic [15:0] IDX_REC_SECOND = 16'h27C1;
  localparam logic [15:0] IDX_PTR_MON = 16'h2741;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_MAX_DEPTH = 8'h01;
  localparam logic [7:0] SUB_ACT_DEPTH = 8'h02;
  localparam logic [7:0] SUB_QUEUE_STYLE = 8'h03;
  localparam logic [7:0] SUB_ENTRY_POINT = 8'h04;
  localparam logic [7:0] SUB_RECORD_SIZE = 8'h05;
  localparam logic [7:0] SUB_BUF_ENABLE = 8'h06;
  localparam logic [7:0] SUB_ABS_REL = 8'h07;
  localparam logic [7:0] SUB_SIGN_INV = 8'h08;
  localparam logic [7:0] SUB_DRAIN = 8'h09;
  localparam logic [7:0] SUB_RD_PTR = 8'h01;
  localparam logic [7:0] SUB_WR_PTR = 8'h02;
  localparam logic [7:0] CFG_ENTRY_COUNT = 8'h09;
  localparam logic [7:0] PTR_ENTRY_COUNT = 8'h02;
  localparam logic [7:0] REC_ENTRY_COUNT = 8'hFE;
  localparam logic [31:0] MAX_DEPTH = 32'h0000_00FE;
  localparam logic [31:0] ACT_DEPTH_RST = 32'h0000_00FE;
  localparam logic [7:0] RECORD_SIZE = 8'h01;
  localparam logic [7:0] PTR_FIRST = 8'h01;
  localparam logic [7:0] PTR_LAST = 8'hFE;
  localparam logic QUEUE_FIFO = 1'b0;
  localparam logic QUEUE_RING = 1'b1;
  localparam logic DATA_ABSOLUTE = 1'b0;
  localparam logic DATA_RELATIVE = 1'b1;
  localparam logic DRAIN_HOLD = 1'b0;
  localparam logic DRAIN_REINIT = 1'b1;
  localparam int REF_FIFO_DEPTH = 32;
  localparam int REF_FIFO_WIDTH = 32;
endpackage : setpoint_pkg

// *** verilog/setpoint_if.sv ***
// object access link between the fieldbus master end and the drive end
`timescale 1ns/1ps
interface setpoint_if;
  logic interp_enable;
  logic req;
  logic we;
  logic [15:0] index;
  logic [7:0] sub;
  logic [31:0] wdata;
  logic ack;
  logic err;
  logic [31:0] rdata;
  modport drive (input interp_enable, req, we, index, sub, wdata, output ack, err, rdata);
  modport master (output interp_enable, req, we, index, sub, wdata, input ack, err, rdata);
endinterface : setpoint_if

// *** verilog/setpoint_master.sv ***
// master end: issues object reads and writes and drives interpolation enable
`timescale 1ns/1ps
module setpoint_master (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // user command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_index,
  input wire logic [7:0] cmd_sub,
  input wire logic [31:0] cmd_wdata,
  input wire logic interp_enable_set,
  // user response
  output logic resp_valid,
  output logic resp_err,
  output logic [31:0] resp_data,
  // object link
  setpoint_if.master link
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} state_t;
  state_t state_r;
  logic req_r;
  logic we_r;
  logic [15:0] index_r;
  logic [7:0] sub_r;
  logic [31:0] wdata_r;
  logic en_r;
  logic resp_err_r;
  logic [31:0] resp_data_r;
  logic locked;
  logic take;

  // style, entry point and profile select stay fixed while interpolating
  assign locked = en_r && cmd_write &&
                  ((cmd_index == setpoint_pkg::IDX_PROFILE_SEL) ||
                   ((cmd_index == setpoint_pkg::IDX_CFG_FIRST ||
                     cmd_index == setpoint_pkg::IDX_CFG_SECOND) &&
                    (cmd_sub == setpoint_pkg::SUB_QUEUE_STYLE ||
                     cmd_sub == setpoint_pkg::SUB_ENTRY_POINT)));
  assign cmd_ready = (state_r == ST_IDLE);
  assign take = ce && cmd_valid && cmd_ready;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      en_r <= 1'b0;
    end else if (ce && state_r == ST_IDLE) begin
      en_r <= interp_enable_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      index_r <= '0;
      sub_r <= '0;
      wdata_r <= '0;
      resp_err_r <= 1'b0;
      resp_data_r <= '0;
    end else if (ce) begin
      req_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (take && locked) begin
            resp_err_r <= 1'b1;
            resp_data_r <= '0;
            state_r <= ST_DONE;
          end else if (take) begin
            req_r <= 1'b1;
            we_r <= cmd_write;
            index_r <= cmd_index;
            sub_r <= cmd_sub;
            wdata_r <= cmd_wdata;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.ack) begin
            resp_err_r <= link.err;
            resp_data_r <= link.rdata;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
      endcase
    end
  end

  assign resp_valid = (state_r == ST_DONE);
  assign resp_err = resp_err_r;
  assign resp_data = resp_data_r;
  assign link.interp_enable = en_r;
  assign link.req = req_r;
  assign link.we = we_r;
  assign link.index = index_r;
  assign link.sub = sub_r;
  assign link.wdata = wdata_r;
endmodule : setpoint_master

// *** test/setpoint_link_monitor.sv ***
// concurrent checks on the object link between master end and drive end
`timescale 1ns/1ps
module setpoint_link_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // object link
  input wire logic interp_enable,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] index,
  input wire logic [7:0] sub,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic cfg_w;
  logic cfg_r;
  assign cfg_w = req && we && index == setpoint_pkg::IDX_CFG_SECOND;
  assign cfg_r = req && !we && index == setpoint_pkg::IDX_CFG_SECOND;
  a_ack_one_cycle: assert property (req |=> ack ##1 !ack)
    else $error("ack not a single cycle after request");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_style_range: assert property (cfg_w && sub == 8'h03 && wdata > 32'h1 |=> ack && err)
    else $error("queue style above 1 accepted");
  a_entry_range: assert property (cfg_w && sub == 8'h04 &&
    (wdata == 32'h0 || wdata > 32'hFE) |=> err)
    else $error("entry point outside 1 to 254 accepted");
  a_enable_range: assert property (cfg_w && sub == 8'h06 && wdata > 32'h1 |=> err)
    else $error("buffer control above 1 accepted");
  a_enable_write_only: assert property (cfg_r && sub == 8'h06 |=> err)
    else $error("buffer control readable");
  a_select_locked: assert property (req && we &&
    index == setpoint_pkg::IDX_PROFILE_SEL && (interp_enable || wdata > 32'h1) |=> err)
    else $error("profile select write accepted");
  a_record_count: assert property (req && !we &&
    index == setpoint_pkg::IDX_REC_SECOND && sub == 8'h00 |=> !err && rdata == 32'h0000_00FE)
    else $error("record entry count wrong");
  a_monitor_read_only: assert property (req && we &&
    index == setpoint_pkg::IDX_PTR_MON |=> err)
    else $error("pointer monitor write accepted");
  a_pointer_range: assert property (req && !we &&
    index == setpoint_pkg::IDX_PTR_MON && (sub == 8'h01 || sub == 8'h02)
    |=> !err && rdata >= 32'h1 && rdata <= 32'hFE)
    else $error("pointer monitor value outside 1 to 254");
endmodule : setpoint_link_monitor

// *** test/interp_setpoint_buffer_tb.sv ***
// self-checking bench: master end and drive end joined over the object link
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module interp_setpoint_buffer_tb;
  logic clk_sys, resetn, ce, cmd_valid, cmd_ready, cmd_write, interp_enable_set;
  logic [15:0] cmd_index;
  logic [7:0] cmd_sub, rd_ptr, wr_ptr;
  logic [31:0] cmd_wdata, resp_data, ref_data;
  logic resp_valid, resp_err, cycle_tick, ref_valid, ref_ready;
  int failures = 0;
  int checked = 0;
  logic [31:0] exp_q[$];
  localparam logic [55:0] BAD [10] = '{56'h2731_03_00000002, 56'h2731_04_00000000,
    56'h2731_04_000000FF, 56'h2731_06_00000002, 56'h2731_05_00000002, 56'h2732_00_00000002,
    56'h27C1_00_00000005, 56'h27C1_FF_00000005, 56'h2741_01_00000003, 56'h1234_00_00000000};
  setpoint_if i_setpoint_if();
  setpoint_master i_setpoint_master (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_index(cmd_index),
    .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .interp_enable_set(interp_enable_set),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data), .link(i_setpoint_if));
  setpoint_drive i_setpoint_drive (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .link(i_setpoint_if), .cycle_tick(cycle_tick), .ref_valid(ref_valid), .ref_ready(ref_ready),
    .ref_data(ref_data), .rd_ptr(rd_ptr), .wr_ptr(wr_ptr));
  setpoint_link_monitor i_setpoint_link_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .interp_enable(i_setpoint_if.interp_enable), .req(i_setpoint_if.req),
    .we(i_setpoint_if.we), .index(i_setpoint_if.index), .sub(i_setpoint_if.sub),
    .wdata(i_setpoint_if.wdata), .ack(i_setpoint_if.ack), .err(i_setpoint_if.err),
    .rdata(i_setpoint_if.rdata));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  // one object access through the master's user side
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] d, input logic ee, input logic [31:0] ed);
    int n;
    n = 0;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_index = ix;
    cmd_sub = sb;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40) failures++;
    `CHK("resp_err", ee, resp_err)
    if (!w && !ee) `CHK("resp_data", ed, resp_data)
  endtask : xfer
  task automatic set_interp(input logic v);
    @(negedge clk_sys);
    interp_enable_set = v;
    repeat (3) @(negedge clk_sys);
  endtask : set_interp
  task automatic tick(input int n);
    @(negedge clk_sys);
    cycle_tick = 1'b1;
    repeat (n) @(negedge clk_sys);
    cycle_tick = 1'b0;
  endtask : tick
  // pops n words; each head is judged before ready lets it go
  task automatic drain(input int n);
    logic [31:0] want;
    for (int k = 0; k < 100 && n > 0; k++) begin
      @(negedge clk_sys);
      ref_ready = (ref_valid === 1'b1);
      if (ref_ready) begin
        want = exp_q.pop_front();
        `CHK("ref_data", want, ref_data)
        n--;
      end
    end
    @(negedge clk_sys);
    ref_ready = 1'b0;
    `CHK("words_left", 0, n)
  endtask : drain
  task automatic t_reset;
    xfer(0, 16'h2741, 8'h01, 0, 0, 32'h1);
    xfer(0, 16'h2741, 8'h02, 0, 0, 32'h1);
    xfer(0, 16'h2731, 8'h00, 0, 0, 32'h9);
    xfer(0, 16'h2731, 8'h01, 0, 0, 32'hFE);
    xfer(0, 16'h2731, 8'h02, 0, 0, 32'hFE);
    xfer(0, 16'h2731, 8'h03, 0, 0, 32'h0);
    xfer(0, 16'h2731, 8'h04, 0, 0, 32'h1);
    xfer(0, 16'h2731, 8'h07, 0, 0, 32'h0);
    xfer(0, 16'h2731, 8'h06, 0, 1, 32'h0);
    xfer(0, 16'h2732, 8'h00, 0, 0, 32'h0);
    xfer(0, 16'h27C1, 8'h00, 0, 0, 32'hFE);
    xfer(0, 16'h27C1, 8'hFE, 0, 0, 32'h0);
  endtask : t_reset
  task automatic t_refuse;
    foreach (BAD[i]) xfer(1, BAD[i][55:40], BAD[i][39:32], BAD[i][31:0], 1, 0);
  endtask : t_refuse
  task automatic t_stream;
    xfer(1, 16'h2732, 8'h00, 32'h1, 0, 0);
    xfer(1, 16'h2731, 8'h08, 32'h1, 0, 0);
    xfer(1, 16'h2731, 8'h06, 32'h1, 0, 0);
    for (int i = 1; i <= 40; i++) begin
      xfer(1, 16'h27C1, 8'(i), 32'h100 + 32'(i), 0, 0);
      exp_q.push_back(32'h100 + 32'(i));
    end
    `CHK("wr_ptr", 8'd41, wr_ptr)
    set_interp(1'b1);
    tick(40);
    `CHK("rd_ptr", 8'd33, rd_ptr)
    drain(32);
    tick(10);
    `CHK("rd_ptr", 8'd41, rd_ptr)
    drain(8);
    `CHK("ref_valid", 1'b0, ref_valid)
    xfer(1, 16'h2732, 8'h00, 32'h0, 1, 0);
    xfer(1, 16'h2731, 8'h03, 32'h1, 1, 0);
    set_interp(1'b0);
  endtask : t_stream
  task automatic t_relative;
    xfer(1, 16'h2731, 8'h06, 32'h0, 0, 0);
    xfer(1, 16'h2731, 8'h06, 32'h1, 0, 0);
    xfer(1, 16'h2731, 8'h07, 32'h1, 0, 0);
    xfer(1, 16'h27C1, 8'h01, 32'h5, 0, 0);
    xfer(1, 16'h27C1, 8'h02, 32'h7, 0, 0);
    xfer(1, 16'h2731, 8'h08, 32'h0, 1, 0);
    exp_q.push_back(32'hFFFF_FFFB);
    exp_q.push_back(32'hFFFF_FFF4);
    set_interp(1'b1);
    tick(3);
    set_interp(1'b0);
    drain(2);
    `CHK("rd_ptr", 8'd3, rd_ptr)
    xfer(1, 16'h2731, 8'h09, 32'h1, 0, 0);
    repeat (3) @(negedge clk_sys);
    `CHK("rd_ptr", 8'd1, rd_ptr)
    `CHK("wr_ptr", 8'd3, wr_ptr)
  endtask : t_relative
  task automatic t_ring;
    xfer(1, 16'h2731, 8'h03, 32'h1, 0, 0);
    exp_q.push_back(32'hFFFF_FFEF);
    exp_q.push_back(32'hFFFF_FFE8);
    set_interp(1'b1);
    tick(2);
    set_interp(1'b0);
    drain(2);
    `CHK("rd_ptr", 8'd3, rd_ptr)
    xfer(1, 16'h2731, 8'h04, 32'hFE, 0, 0);
    xfer(0, 16'h2731, 8'h04, 0, 0, 32'hFE);
    `CHK("wr_ptr", 8'hFE, wr_ptr)
    xfer(1, 16'h27C1, 8'hFE, 32'h9, 0, 0);
    `CHK("wr_ptr", 8'h01, wr_ptr)
    xfer(1, 16'h2732, 8'h00, 32'h0, 0, 0);
    xfer(0, 16'h27C0, 8'h01, 0, 0, 32'h0);
    xfer(0, 16'h27C1, 8'h01, 0, 0, 32'h5);
    xfer(1, 16'h2730, 8'h02, 32'h80, 0, 0);
    xfer(0, 16'h2730, 8'h02, 0, 0, 32'h80);
    xfer(1, 16'h2730, 8'h05, 32'h1, 0, 0);
    xfer(0, 16'h2730, 8'h03, 0, 0, 32'h0);
  endtask : t_ring
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_index = 16'h0;
    cmd_sub = 8'h0;
    cmd_wdata = 32'h0;
    interp_enable_set = 1'b0;
    cycle_tick = 1'b0;
    ref_ready = 1'b0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset();
    t_refuse();
    t_stream();
    t_relative();
    t_ring();
    finish_test();
  end
  // about 500 cycles are expected; cut off well beyond
  initial begin
    #(20000 * 50);
    failures++;
    finish_test();
  end
endmodule : interp_setpoint_buffer_tb
